// >>> logic/mpc_pkg.sv
/*
 * Package for the module power control sideband block: APB register map,
 * field positions, reset values, timing constants and state encodings.
 * Assumes a 20 MHz pclk shared by every user of the package.
 */
`default_nettype none
package mpc_pkg;

   // ********************************************************************
   // Timing
   // ********************************************************************
   localparam int unsigned CLK_HZ           = 20_000_000;
   localparam int unsigned DEBOUNCE_MS      = 16;
   localparam int unsigned RESPONSE_MS      = 200;
   localparam int unsigned LONG_HOLD_MS     = 4000;
   localparam int unsigned TICK_US          = 1000;
   localparam int unsigned TICK_CYCLES      = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned DEBOUNCE_TICKS   = DEBOUNCE_MS * 1000 / TICK_US;
   localparam int unsigned LONG_HOLD_TICKS  = LONG_HOLD_MS * 1000 / TICK_US;

   // ********************************************************************
   // Register map (byte addresses)
   // ********************************************************************
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_IRQ    = 12'h008;
   localparam logic [11:0] ADDR_MASK   = 12'h00c;

   // CTRL fields
   localparam int unsigned CTRL_FAN_BIT   = 0;
   localparam int unsigned CTRL_SHUT_BIT  = 1;
   localparam int unsigned CTRL_WAKE_BIT  = 2;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

   // IRQ / MASK fields
   localparam int unsigned IRQ_PRESS_BIT  = 0;
   localparam int unsigned IRQ_ON_BIT     = 1;
   localparam int unsigned IRQ_OFF_BIT    = 2;
   localparam int unsigned IRQ_FORCE_BIT  = 3;
   localparam int unsigned IRQ_W          = 4;
   localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;

   // ********************************************************************
   // Types
   // ********************************************************************
   typedef enum logic [1:0] {
      MPC_SOFT_OFF = 2'b00,
      MPC_WAKING   = 2'b01,
      MPC_ON       = 2'b11,
      MPC_SLEEPING = 2'b10
   } mpc_pstate_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } mpc_apb_req_s;

endpackage : mpc_pkg
`default_nettype wire

// >>> logic/mpc_sideband.sv
/*
 * Sideband power control of a plug-in module: request input debounce,
 * button-style power state machine, status, presence and fan outputs,
 * APB register slave with sticky interrupts.
 * Assumes power_on_request_n is asynchronous and pulled up externally,
 * open-collector outputs are pulled up on the panel side.
 */
// Local design decisions: the APB interface to the registers and the register offsets.
//
// Contract
// - Power status output low while powered on, released high while off.
// - Low request pulse detected and answered within 200 ms.
// - Request input debounced internally for 16 ms.
// - From soft-off, power-up starts on debounced press, not release.
// - Held low four seconds in S0-S4 forces soft-off.
// - Presence output held low to show module installed.
// - Fan requested only when the thermal controller needs cooling; the code also requests it while powered with the CTRL fan bit set.
`timescale 1ns/10ps
`default_nettype none
module mpc_sideband #(
   parameter int unsigned TICK_CYCLES_P     = mpc_pkg::TICK_CYCLES,
   parameter int unsigned DEBOUNCE_TICKS_P  = mpc_pkg::DEBOUNCE_TICKS,
   parameter int unsigned LONG_HOLD_TICKS_P = mpc_pkg::LONG_HOLD_TICKS
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire mpc_pkg::mpc_apb_req_s apb_req,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   input  wire logic                  power_on_request_n,
   input  wire logic                  embedded_thermal_controller,
   input  wire logic                  platform_sleep,
   output logic                       module_power_state_out,
   output logic                       module_power_state_oe,
   output logic                       module_present_n,
   output logic                       fan_request_n,
   output logic                       fan_request_oe,
   output logic                       cec_out,
   output logic                       cec_oe,
   input  wire logic                  cec_in,
   output logic                       irq
);
   import mpc_pkg::*;

   // ********************************************************************
   // Declarations
   // ********************************************************************
   logic [1:0]        req_sync_r;
   logic [1:0]        cec_sync_r;
   logic [1:0]        sleep_sync_r;
   logic [15:0]       tick_cnt_r;
   logic              tick_r;
   logic              req_db_r;
   logic [15:0]       db_cnt_r;
   logic              press_r;
   logic [15:0]       hold_cnt_r;
   logic              force_off_r;
   mpc_pstate_e       pstate_r;
   logic [31:0]       ctrl_r;
   logic [IRQ_W-1:0]  irq_stat_r;
   logic [IRQ_W-1:0]  irq_mask_r;
   logic [IRQ_W-1:0]  irq_evt;
   logic              fan_nxt;
   logic              access;
   logic              wr_en;
   logic              rd_irq;
   logic              powered;
   logic              req_low;

   function automatic logic apb_hit(input logic [11:0] a, input logic [11:0] base);
      return a == base;
   endfunction : apb_hit

   assign access  = apb_req.psel & apb_req.penable;
   assign wr_en   = access & apb_req.pwrite;
   assign rd_irq  = access & ~apb_req.pwrite & apb_hit(apb_req.paddr, ADDR_IRQ);
   assign powered = (pstate_r != MPC_SOFT_OFF);
   assign req_low = ~req_sync_r[1];

   // ********************************************************************
   // Synchronisers
   // ********************************************************************
   // Async pin: first stage is read only by the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_sync_r   <= 2'h3;
         cec_sync_r   <= 2'h3;
         sleep_sync_r <= 2'h0;
      end else begin
         req_sync_r   <= {req_sync_r[0], power_on_request_n};
         cec_sync_r   <= {cec_sync_r[0], cec_in};
         sleep_sync_r <= {sleep_sync_r[0], platform_sleep};
      end
   end

   // ********************************************************************
   // Millisecond tick
   // ********************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_r <= 16'h0000;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == 16'(TICK_CYCLES_P - 1)) begin
         tick_cnt_r <= 16'h0000;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
         tick_r     <= 1'b0;
      end
   end

   // ********************************************************************
   // Debounce: level must be stable for the full window
   // ********************************************************************
   // Total detection latency is at most about 16 ms, well inside 200 ms
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_db_r <= 1'b0;
         db_cnt_r <= 16'h0000;
         press_r  <= 1'b0;
      end else begin
         press_r <= 1'b0;
         if (req_low == req_db_r) begin
            db_cnt_r <= 16'h0000;
         end else if (tick_r) begin
            if (db_cnt_r == 16'(DEBOUNCE_TICKS_P - 1)) begin
               db_cnt_r <= 16'h0000;
               req_db_r <= req_low;
               press_r  <= req_low;
            end else begin
               db_cnt_r <= db_cnt_r + 16'h0001;
            end
         end
      end
   end

   // ********************************************************************
   // Long hold counter
   // ********************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt_r  <= 16'h0000;
         force_off_r <= 1'b0;
      end else begin
         force_off_r <= 1'b0;
         if (!req_db_r || !powered) begin
            hold_cnt_r <= 16'h0000;
         end else if (tick_r && hold_cnt_r != 16'(LONG_HOLD_TICKS_P)) begin
            hold_cnt_r <= hold_cnt_r + 16'h0001;
            if (hold_cnt_r == 16'(LONG_HOLD_TICKS_P - 1)) begin
               force_off_r <= 1'b1;
            end
         end
      end
   end

   // ********************************************************************
   // Power state machine
   // ********************************************************************
   // A press while on only wakes a sleeping module; shutdown needs the hold or the CTRL shut bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pstate_r <= MPC_SOFT_OFF;
      end else if (force_off_r || ctrl_r[CTRL_SHUT_BIT]) begin
         pstate_r <= MPC_SOFT_OFF;
      end else begin
         unique case (pstate_r)
            MPC_SOFT_OFF: if (press_r || ctrl_r[CTRL_WAKE_BIT]) begin
               pstate_r <= MPC_WAKING;
            end
            MPC_WAKING:   pstate_r <= MPC_ON;
            MPC_ON:       if (sleep_sync_r[1]) begin
               pstate_r <= MPC_SLEEPING;
            end
            MPC_SLEEPING: if (press_r || !sleep_sync_r[1]) begin
               pstate_r <= MPC_ON;
            end
         endcase
      end
   end

   // ********************************************************************
   // Pin outputs
   // ********************************************************************
   // Open collector: enable low means pin is pulled to ground
   always_comb begin
      fan_nxt = embedded_thermal_controller | ctrl_r[CTRL_FAN_BIT];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         module_power_state_out <= 1'b0;
         module_power_state_oe  <= 1'b1;
         module_present_n       <= 1'b0;
         fan_request_n          <= 1'b1;
         fan_request_oe         <= 1'b1;
         cec_out                <= 1'b0;
         cec_oe                 <= 1'b1;
      end else begin
         module_power_state_out <= 1'b0;
         module_power_state_oe  <= ~powered;
         module_present_n       <= 1'b0;
         fan_request_n          <= ~(fan_nxt & powered);
         fan_request_oe         <= ~(fan_nxt & powered);
         cec_out                <= 1'b0;
         cec_oe                 <= 1'b1;
      end
   end

   // ********************************************************************
   // Interrupts
   // ********************************************************************
   always_comb begin
      irq_evt                = '0;
      irq_evt[IRQ_PRESS_BIT] = press_r;
      irq_evt[IRQ_ON_BIT]    = (pstate_r == MPC_WAKING);
      irq_evt[IRQ_OFF_BIT]   = powered && (force_off_r || ctrl_r[CTRL_SHUT_BIT]);
      irq_evt[IRQ_FORCE_BIT] = force_off_r;
   end

   // Set wins over the read-clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (rd_irq ? '0 : irq_stat_r) | irq_evt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((rd_irq ? '0 : irq_stat_r) | irq_evt) & irq_mask_r);
      end
   end

   // ********************************************************************
   // APB slave
   // ********************************************************************
   // Answers in the access phase, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r     <= CTRL_RESET;
         irq_mask_r <= MASK_RESET;
      end else begin
         ctrl_r[CTRL_SHUT_BIT] <= 1'b0;
         ctrl_r[CTRL_WAKE_BIT] <= 1'b0;
         if (wr_en && apb_hit(apb_req.paddr, ADDR_CTRL)) begin
            ctrl_r <= {29'h0, apb_req.pwdata[2:0]};
         end
         if (wr_en && apb_hit(apb_req.paddr, ADDR_MASK)) begin
            irq_mask_r <= apb_req.pwdata[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= apb_req.psel & ~apb_req.penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (apb_req.psel && !apb_req.penable) begin
            pslverr <= ~(apb_hit(apb_req.paddr, ADDR_CTRL)
                       | apb_hit(apb_req.paddr, ADDR_STATUS)
                       | apb_hit(apb_req.paddr, ADDR_IRQ)
                       | apb_hit(apb_req.paddr, ADDR_MASK));
            if (!apb_req.pwrite) begin
               unique case (apb_req.paddr)
                  ADDR_CTRL:   prdata <= ctrl_r;
                  ADDR_STATUS: prdata <= {26'h0, cec_sync_r[1], req_db_r,
                                          pstate_r, ~fan_request_n, powered};
                  ADDR_IRQ:    prdata <= {28'h0, irq_stat_r | irq_evt};
                  ADDR_MASK:   prdata <= {28'h0, irq_mask_r};
                  default:     prdata <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   // ********************************************************************
   // Assertions
   // ********************************************************************
   sequence s_press;
      press_r && pstate_r == MPC_SOFT_OFF && !force_off_r;
   endsequence

   property p_boot_on_press;
      @(posedge pclk) disable iff (!presetn)
      s_press |=> pstate_r == MPC_WAKING ##1 pstate_r == MPC_ON;
   endproperty
   a_boot_on_press: assert property (p_boot_on_press)
      else $error("press from soft-off did not boot");

   property p_status_low_on;
      @(posedge pclk) disable iff (!presetn)
      powered |=> !module_power_state_oe;
   endproperty
   a_status_low_on: assert property (p_status_low_on)
      else $error("power status not driven low while on");

   property p_status_rel_off;
      @(posedge pclk) disable iff (!presetn)
      !powered |=> module_power_state_oe;
   endproperty
   a_status_rel_off: assert property (p_status_rel_off)
      else $error("power status not released while off");

   property p_force_off;
      @(posedge pclk) disable iff (!presetn)
      force_off_r |=> pstate_r == MPC_SOFT_OFF;
   endproperty
   a_force_off: assert property (p_force_off)
      else $error("long hold did not force soft-off");

   property p_force_count;
      @(posedge pclk) disable iff (!presetn)
      force_off_r |-> hold_cnt_r == 16'(LONG_HOLD_TICKS_P) && req_db_r;
   endproperty
   a_force_count: assert property (p_force_count)
      else $error("forced off before full hold time");

   property p_db_stable;
      @(posedge pclk) disable iff (!presetn)
      $changed(req_db_r) |-> req_low == req_db_r && tick_r == 1'b0;
   endproperty
   a_db_stable: assert property (p_db_stable)
      else $error("debounced level disagrees with input");

   property p_press_level;
      @(posedge pclk) disable iff (!presetn)
      press_r |-> req_db_r && $rose(req_db_r);
   endproperty
   a_press_level: assert property (p_press_level)
      else $error("press without debounced assertion");

   property p_present;
      @(posedge pclk) disable iff (!presetn)
      ##1 !module_present_n;
   endproperty
   a_present: assert property (p_present)
      else $error("presence output not low");

   property p_fan;
      @(posedge pclk) disable iff (!presetn)
      !fan_request_n |-> $past(fan_nxt) && $past(powered);
   endproperty
   a_fan: assert property (p_fan)
      else $error("fan requested without need");

   property p_sync;
      @(posedge pclk) disable iff (!presetn)
      req_sync_r[1] == $past(req_sync_r[0]);
   endproperty
   a_sync: assert property (p_sync)
      else $error("request synchroniser skipped a stage");

endmodule : mpc_sideband
`default_nettype wire

// >>> test/mpc_panel_model.sv
/*
 * Panel control board model: power-on request and CEC drive, pull-ups of
 * the open-collector pins. Assumes the block's pclk and presetn.
 */
`timescale 1ns/10ps
`default_nettype none
module mpc_panel_model #(
   parameter int unsigned STARTUP_CYCLES = 20
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic press_hold,
   input  wire logic cec_pull_low,
   input  wire logic power_state_out,
   input  wire logic power_state_oe,
   input  wire logic fan_out,
   input  wire logic fan_oe,
   input  wire logic cec_out,
   input  wire logic cec_oe,
   output logic      request_n,
   output logic      request_allowed,
   output logic      power_level,
   output logic      fan_level,
   output logic      cec_level
);
   int unsigned up_cnt_r;

   // Supply settle time before any request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_cnt_r <= 0;
      end else if (up_cnt_r < STARTUP_CYCLES) begin
         up_cnt_r <= up_cnt_r + 1;
      end
   end
   assign request_allowed = (up_cnt_r >= STARTUP_CYCLES);
   // Pulled up on the module side when not sunk
   assign request_n = !(press_hold && request_allowed);
   // Released pins read high through the panel pull-ups
   assign power_level = power_state_oe ? 1'b1 : power_state_out;
   assign fan_level = fan_oe ? 1'b1 : fan_out;
   // Wired-AND CEC line shared with the panel processor
   assign cec_level = (cec_oe ? 1'b1 : cec_out) & !cec_pull_low;
endmodule : mpc_panel_model
`default_nettype wire

// >>> test/tb_top.sv
/*
 * Self-checking bench of the sideband block with shortened timing.
 * Assumes the panel model in its own file and APB at zero wait.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import mpc_pkg::*;
   logic         pclk;
   logic         presetn;
   mpc_apb_req_s apb_req;
   logic         pready;
   logic         pslverr;
   logic [31:0]  prdata;
   logic [31:0]  rd;
   logic         err;
   logic         req_n;
   logic         thermal;
   logic         sleep;
   logic         pwr_out;
   logic         pwr_oe;
   logic         present_n;
   logic         fan_n;
   logic         fan_oe;
   logic         cec_out;
   logic         cec_oe;
   logic         cec_lvl;
   logic         irq;
   logic         press;
   logic         cec_low;
   logic         allowed;
   logic         pwr_lvl;
   logic         fan_lvl;
   int           n;
   int           miscompares;
   int           total_checks;

   mpc_sideband #(.TICK_CYCLES_P(4), .DEBOUNCE_TICKS_P(2), .LONG_HOLD_TICKS_P(6)) mpc_sideband_i (
      .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .power_on_request_n(req_n),
      .embedded_thermal_controller(thermal), .platform_sleep(sleep),
      .module_power_state_out(pwr_out), .module_power_state_oe(pwr_oe),
      .module_present_n(present_n), .fan_request_n(fan_n), .fan_request_oe(fan_oe),
      .cec_out(cec_out), .cec_oe(cec_oe), .cec_in(cec_lvl), .irq(irq));

   mpc_panel_model mpc_panel_model_i (
      .pclk(pclk), .presetn(presetn), .press_hold(press), .cec_pull_low(cec_low),
      .power_state_out(pwr_out), .power_state_oe(pwr_oe), .fan_out(fan_n),
      .fan_oe(fan_oe), .cec_out(cec_out), .cec_oe(cec_oe), .request_n(req_n),
      .request_allowed(allowed), .power_level(pwr_lvl), .fan_level(fan_lvl),
      .cec_level(cec_lvl));

   // ******************************************************************
   // Shared tasks
   // ******************************************************************
   task automatic conclude;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   task automatic hang;
      miscompares++;
      conclude();
   endtask : hang

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) hang();
      rd = prdata;
      err = pslverr;
      apb_req <= '0;
   endtask : apb

   task automatic wait_pwr(input logic lvl, input int max);
      for (n = 0; n < max; n++) begin
         @(posedge pclk);
         if (pwr_lvl === lvl) return;
      end
      hang();
   endtask : wait_pwr

   // ******************************************************************
   // Scenarios
   // ******************************************************************
   task automatic t_reset;
      check(present_n, 1'b0);
      check(pwr_lvl, 1'b1);
      check(fan_lvl, 1'b1);
      check(irq, 1'b0);
      apb(1'b0, ADDR_CTRL, 0);
      check(rd, CTRL_RESET);
      apb(1'b0, ADDR_MASK, 0);
      check(rd, 32'(MASK_RESET));
      apb(1'b0, 12'h010, 0);
      check(err, 1'b1);
      check(rd, 32'h0);
   endtask : t_reset

   task automatic t_glitch_then_on;
      for (n = 0; n < 100 && allowed !== 1'b1; n++) @(posedge pclk);
      if (allowed !== 1'b1) hang();
      apb(1'b1, ADDR_MASK, 32'hf);
      press <= 1'b1;
      repeat (3) @(posedge pclk);
      press <= 1'b0;
      repeat (40) @(posedge pclk);
      check(pwr_lvl, 1'b1);
      press <= 1'b1;
      wait_pwr(1'b0, 60);
      check(32'(n >= 5), 32'h1);
      check(32'(n <= 24), 32'h1);
      check(req_n, 1'b0);
      press <= 1'b0;
      check(irq, 1'b1);
      apb(1'b0, ADDR_IRQ, 0);
      check(rd, 32'h3);
      repeat (2) @(posedge pclk);
      check(irq, 1'b0);
   endtask : t_glitch_then_on

   task automatic t_ignore_then_force;
      apb(1'b1, ADDR_MASK, 32'h8);
      press <= 1'b1;
      repeat (16) @(posedge pclk);
      press <= 1'b0;
      repeat (40) @(posedge pclk);
      check(pwr_lvl, 1'b0);
      check(irq, 1'b0);
      press <= 1'b1;
      wait_pwr(1'b1, 80);
      check(32'(n >= 20), 32'h1);
      press <= 1'b0;
      repeat (2) @(posedge pclk);
      check(irq, 1'b1);
      apb(1'b0, ADDR_IRQ, 0);
      check(rd & 32'hc, 32'hc);
   endtask : t_ignore_then_force

   task automatic t_sleep_force;
      apb(1'b1, ADDR_CTRL, 32'h4);
      wait_pwr(1'b0, 20);
      apb(1'b0, ADDR_CTRL, 0);
      check(rd, 32'h0);
      sleep <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 0);
      check(rd & 32'h2f, 32'h29);
      press <= 1'b1;
      wait_pwr(1'b1, 80);
      check(32'(n >= 20), 32'h1);
      press <= 1'b0;
      sleep <= 1'b0;
   endtask : t_sleep_force

   task automatic t_fan;
      thermal <= 1'b1;
      repeat (3) @(posedge pclk);
      check(fan_lvl, 1'b1);
      apb(1'b1, ADDR_CTRL, 32'h4);
      wait_pwr(1'b0, 20);
      repeat (2) @(posedge pclk);
      check(fan_lvl, 1'b0);
      thermal <= 1'b0;
      repeat (3) @(posedge pclk);
      check(fan_lvl, 1'b1);
      apb(1'b1, ADDR_CTRL, 32'h1);
      repeat (2) @(posedge pclk);
      check(fan_lvl, 1'b0);
      apb(1'b1, ADDR_CTRL, 32'h0);
      repeat (2) @(posedge pclk);
      check(fan_lvl, 1'b1);
      apb(1'b1, ADDR_CTRL, 32'h2);
      wait_pwr(1'b1, 20);
      check(pwr_lvl, 1'b1);
   endtask : t_fan

   task automatic t_cec;
      cec_low <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 0);
      check(rd[5], 1'b0);
      cec_low <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 0);
      check(rd[5], 1'b1);
   endtask : t_cec

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   initial begin
      miscompares = 0;
      total_checks = 0;
      presetn = 1'b0;
      apb_req = '0;
      thermal = 1'b0;
      sleep = 1'b0;
      press = 1'b0;
      cec_low = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_glitch_then_on();
      t_ignore_then_force();
      t_sleep_force();
      t_fan();
      t_cec();
      conclude();
   end
endmodule : tb_top
`default_nettype wire
